// file: hw/isc_pkg.sv
package isc_pkg;

   // configuration word layout
   localparam int         CFG_W       = 12;
   localparam int         REV_W       = 4;
   localparam int         RANGE_MSB   = 11;
   localparam int         RANGE_LSB   = 9;
   localparam int         FMT_BIT     = 8;
   localparam logic [11:0] CFG_DEFAULT = 12'hE00;
   localparam logic [3:0] REV_ID      = 4'hA; // arbitrary value

   // readback sequence
   localparam int          RB_REPEAT      = 2;
   localparam int          RB_TOTAL_SHORT = 512;
   localparam int          RB_TOTAL_LONG  = 640;
   localparam int          HALF_SHORT     = RB_TOTAL_SHORT / RB_REPEAT;
   localparam int          HALF_LONG      = RB_TOTAL_LONG / RB_REPEAT;
   localparam int          PAT_LEN_SHORT  = HALF_SHORT - CFG_W - REV_W;
   localparam int          PAT_LEN_LONG   = 304;
   localparam int          PAT_NZ_SHORT   = 56;
   localparam int          PAT_NZ_LONG    = 72;
   localparam logic [55:0] PAT_SHORT      = 56'h30F066012480F6;
   localparam logic [71:0] PAT_LONG       = 72'h30F066012480F69055;

   // converter geometry
   localparam int NUM_IN  = 32;
   localparam int NUM_ADC = 16;
   localparam int RES_W   = 20;

   // feedback capacitor (0.1 pF units) and full-scale charge (0.1 pC units)
   localparam logic [9:0] CAP_TENTH_PF [8] = '{10'h01E, 10'h07D, 10'h0FA, 10'h177,
                                               10'h1F4, 10'h271, 10'h2EE, 10'h36B};
   localparam logic [11:0] FS_TENTH_PC [8] = '{12'h07D, 12'h1F4, 12'h3E8, 12'h5DC,
                                               12'h7D0, 12'h9C4, 12'hBB8, 12'hDAC};

   // timing
   localparam int CLK_NS     = 10;
   localparam int T_RST_NS   = 1000;
   localparam int T_WTRST_NS = 2000;
   localparam int T_WTWR_NS  = 2000;
   localparam int RST_CYC    = (T_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int WTRST_CYC  = (T_WTRST_NS + CLK_NS - 1) / CLK_NS;
   localparam int WTWR_CYC   = (T_WTWR_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCK_HALF   = 6;
   localparam int SYS_HALF   = 6;
   localparam int CONVERT_STROBE_TICKS = 64;
   localparam int RST_TICKS  = 16;

   // positions in the synchronised pin vector of the device
   localparam int IN_SYS   = 0;
   localparam int IN_CONVERT_STROBE  = 1;
   localparam int IN_RSTN  = 2;
   localparam int IN_SCK   = 3;
   localparam int IN_DIN   = 4;
   localparam int IN_DATA_SHIFT_CLOCK  = 5;
   localparam int IN_CHAIN = 6;
   localparam int IN_N     = 7;

   typedef enum logic [1:0] {
      IS_RESET = 2'b00,
      IS_WAIT  = 2'b01,
      IS_INTEG = 2'b10,
      IS_CONVERT_STROBE  = 2'b11
   } isc_side_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_RST  = 3'b001,
      H_WRST = 3'b010,
      H_WR   = 3'b011,
      H_WWR  = 3'b100,
      H_RD   = 3'b101,
      H_DATA = 3'b110
   } isc_host_t;

endpackage

// file: hw/isc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface isc_link_if;
   logic system_clock;
   logic convert_strobe;
   logic cfg_reset_n;
   logic config_shift_clock;
   logic config_serial_in;
   logic data_shift_clock;
   logic serial_data_out;
   logic output_ready_n;
   logic chain_in;

   modport dev (
      input  system_clock, convert_strobe, cfg_reset_n, config_shift_clock,
      input  config_serial_in, data_shift_clock, chain_in,
      output serial_data_out, output_ready_n
   );

   modport host (
      output system_clock, convert_strobe, cfg_reset_n, config_shift_clock,
      output config_serial_in, data_shift_clock,
      input  serial_data_out, output_ready_n
   );
endinterface
`default_nettype wire

// file: hw/isc_dev.sv
`timescale 1ns/100ps
`default_nettype none
module isc_dev
   import isc_pkg::*;
#(
   parameter int N_IN     = NUM_IN,
   parameter int W_RES    = RES_W,
   parameter int T_CONVERT_STROBE   = CONVERT_STROBE_TICKS,
   parameter int T_RESET  = RST_TICKS
) (
   // clock, reset, enable
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   // link to the host
   isc_link_if.dev                         lnk,
   // converter results for the side now being converted
   input  wire logic                       res_we,
   input  wire logic [$clog2(N_IN)-1:0]    res_idx,
   input  wire logic [W_RES-1:0]           res_data,
   // configuration and integrator state
   output logic      [CFG_W-1:0]           cfg_word_q,
   output logic      [2:0]                 full_scale_q,
   output logic      [9:0]                 fb_cap_q,
   output logic      [11:0]                fs_charge_q,
   output logic                            integ_a_q,
   output logic                            integ_b_q,
   output logic                            ref_conn_a_q,
   output logic                            ref_conn_b_q,
   output logic                            adc_busy_q,
   output logic                            adc_side_b_q,
   output logic                            adc_mux_hi_q,
   output logic      [1:0]                 convert_strobe_done_q
);

   localparam int OUT_BITS = 2 * N_IN * W_RES;
   localparam int IDX_W    = $clog2((OUT_BITS > RB_TOTAL_LONG ? OUT_BITS : RB_TOTAL_LONG) + 1);
   localparam int TCK_W    = 16;

   logic [IN_N-1:0]     s1_q, s2_q, s3_q;
   logic                sys_tick, convert_strobe_rise, convert_strobe_fall, sck_fall, data_shift_clock_rise, cfg_rst;
   logic [1:0]          start_ev, stop_ev;
   isc_side_t           st_q [2];
   logic [TCK_W-1:0]    tick_q [2];
   logic [CFG_W-1:0]    cfg_q, wr_sh_q, cfg_next;
   logic [3:0]          wr_cnt_q;
   logic                cfg_commit;
   logic                rb_mode_q;
   logic                dout_q, ready_n_q;
   logic [IDX_W-1:0]    out_idx_q;
   logic [W_RES-1:0]    res_mem [2*N_IN];

   // every pin from the host crosses through two flops; s3 only feeds edge detection
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (clk_en) begin
         s1_q <= {lnk.chain_in, lnk.data_shift_clock, lnk.config_serial_in,
                  lnk.config_shift_clock, lnk.cfg_reset_n, lnk.convert_strobe,
                  lnk.system_clock};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // edge events seen on the synchronised pins
   assign sys_tick  = s2_q[IN_SYS] & ~s3_q[IN_SYS];
   assign convert_strobe_rise = s2_q[IN_CONVERT_STROBE] & ~s3_q[IN_CONVERT_STROBE];
   assign convert_strobe_fall = ~s2_q[IN_CONVERT_STROBE] & s3_q[IN_CONVERT_STROBE];
   assign sck_fall  = ~s2_q[IN_SCK] & s3_q[IN_SCK];
   assign data_shift_clock_rise = s2_q[IN_DATA_SHIFT_CLOCK] & ~s3_q[IN_DATA_SHIFT_CLOCK];
   assign cfg_rst   = ~s2_q[IN_RSTN];
   assign start_ev  = {convert_strobe_fall, convert_strobe_rise};
   assign stop_ev   = {convert_strobe_rise, convert_strobe_fall};

   // bit k of the readback stream for a given configuration word
   function automatic logic rb_bit(input logic [IDX_W-1:0] idx, input logic [CFG_W-1:0] cfg);
      int   half;
      int   plen;
      int   k;
      int   p;
      logic lng;
      lng  = cfg[FMT_BIT];
      half = lng ? HALF_LONG : HALF_SHORT;
      plen = lng ? PAT_LEN_LONG : PAT_LEN_SHORT;
      k    = int'(idx);
      if (k >= half) k = k - half;
      if (k < CFG_W) return cfg[CFG_W-1-k];
      if (k < CFG_W + REV_W) return REV_ID[CFG_W+REV_W-1-k];
      p = plen - 1 - (k - CFG_W - REV_W);
      if (lng) return (p < PAT_NZ_LONG) ? PAT_LONG[p] : 1'b0;
      return (p < PAT_NZ_SHORT) ? PAT_SHORT[p] : 1'b0;
   endfunction

   // bit k of the result stream: input by input, side A word then side B word, MSB first
   function automatic logic data_bit(input logic [IDX_W-1:0] idx);
      int w;
      int b;
      w = int'(idx) / W_RES;
      b = W_RES - 1 - (int'(idx) % W_RES);
      return res_mem[w][b];
   endfunction

   // two integrators per input, each walking reset, wait, integrate, convert
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int s = 0; s < 2; s++) begin
            st_q[s]   <= IS_RESET;
            tick_q[s] <= '0;
         end
         convert_strobe_done_q <= '0;
      end else if (clk_en) begin
         convert_strobe_done_q <= '0;
         for (int s = 0; s < 2; s++) begin
            if (cfg_rst) begin
               st_q[s]   <= IS_RESET;
               tick_q[s] <= '0;
            end else begin
               case (st_q[s])
                  IS_RESET: begin
                     if (sys_tick) begin
                        if (tick_q[s] == TCK_W'(T_RESET - 1)) begin
                           st_q[s]   <= IS_WAIT;
                           tick_q[s] <= '0;
                        end else begin
                           tick_q[s] <= tick_q[s] + 1'b1;
                        end
                     end
                  end
                  IS_WAIT: begin
                     if (start_ev[s]) st_q[s] <= IS_INTEG;
                  end
                  IS_INTEG: begin
                     if (stop_ev[s]) begin
                        st_q[s]   <= IS_CONVERT_STROBE;
                        tick_q[s] <= '0;
                     end
                  end
                  IS_CONVERT_STROBE: begin
                     if (sys_tick) begin
                        if (tick_q[s] == TCK_W'(T_CONVERT_STROBE - 1)) begin
                           st_q[s]        <= IS_RESET;
                           tick_q[s]      <= '0;
                           convert_strobe_done_q[s] <= 1'b1;
                        end else begin
                           tick_q[s] <= tick_q[s] + 1'b1;
                        end
                     end
                  end
                  default: st_q[s] <= IS_RESET;
               endcase
            end
         end
      end
   end

   // results land in the slot of the side being converted
   always_ff @(posedge core_clk) begin
      if (clk_en && res_we) begin
         res_mem[{res_idx, (st_q[1] == IS_CONVERT_STROBE)}] <= res_data;
      end
   end

   // configuration shift; the live word is replaced only on the twelfth bit
   assign cfg_next   = {wr_sh_q[CFG_W-2:0], s2_q[IN_DIN]};
   assign cfg_commit = sck_fall & ~cfg_rst & (wr_cnt_q == 4'(CFG_W - 1));
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_q    <= CFG_DEFAULT;
         wr_sh_q  <= '0;
         wr_cnt_q <= '0;
      end else if (clk_en) begin
         if (cfg_rst) begin
            wr_cnt_q <= '0;
         end else if (sck_fall && wr_cnt_q < 4'(CFG_W)) begin
            wr_sh_q  <= cfg_next;
            wr_cnt_q <= wr_cnt_q + 1'b1;
            if (cfg_commit) cfg_q <= cfg_next;
         end
      end
   end

   // serial output: readback after a write, results after a conversion, then the chain
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rb_mode_q <= 1'b0;
         dout_q    <= 1'b0;
         ready_n_q <= 1'b1;
         out_idx_q <= '0;
      end else if (clk_en) begin
         if (cfg_commit) begin
            rb_mode_q <= 1'b1;
            dout_q    <= rb_bit('0, cfg_next);
            out_idx_q <= IDX_W'(1);
         end else if (convert_strobe_rise) begin
            rb_mode_q <= 1'b0;
         end else if (|convert_strobe_done_q) begin
            rb_mode_q <= 1'b0;
            ready_n_q <= 1'b0;
            dout_q    <= data_bit('0);
            out_idx_q <= IDX_W'(1);
         end else if (data_shift_clock_rise) begin
            ready_n_q <= 1'b1;
            if (rb_mode_q && out_idx_q < IDX_W'(cfg_q[FMT_BIT] ? RB_TOTAL_LONG : RB_TOTAL_SHORT)) begin
               dout_q    <= rb_bit(out_idx_q, cfg_q);
               out_idx_q <= out_idx_q + 1'b1;
            end else if (!rb_mode_q && out_idx_q < IDX_W'(OUT_BITS)) begin
               dout_q    <= data_bit(out_idx_q);
               out_idx_q <= out_idx_q + 1'b1;
            end else begin
               dout_q <= s2_q[IN_CHAIN];
            end
         end
      end
   end

   assign lnk.serial_data_out = dout_q;
   assign lnk.output_ready_n  = ready_n_q;

   // registered views; the mux flag says which half of the inputs the 16 converters see
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_word_q   <= CFG_DEFAULT;
         full_scale_q <= CFG_DEFAULT[RANGE_MSB:RANGE_LSB];
         fb_cap_q     <= CAP_TENTH_PF[CFG_DEFAULT[RANGE_MSB:RANGE_LSB]];
         fs_charge_q  <= FS_TENTH_PC[CFG_DEFAULT[RANGE_MSB:RANGE_LSB]];
         integ_a_q    <= 1'b0;
         integ_b_q    <= 1'b0;
         ref_conn_a_q <= 1'b0;
         ref_conn_b_q <= 1'b0;
         adc_busy_q   <= 1'b0;
         adc_side_b_q <= 1'b0;
         adc_mux_hi_q <= 1'b0;
      end else if (clk_en) begin
         cfg_word_q   <= cfg_q;
         full_scale_q <= cfg_q[RANGE_MSB:RANGE_LSB];
         fb_cap_q     <= CAP_TENTH_PF[cfg_q[RANGE_MSB:RANGE_LSB]];
         fs_charge_q  <= FS_TENTH_PC[cfg_q[RANGE_MSB:RANGE_LSB]];
         integ_a_q    <= (st_q[0] == IS_INTEG);
         integ_b_q    <= (st_q[1] == IS_INTEG);
         ref_conn_a_q <= (st_q[0] == IS_RESET);
         ref_conn_b_q <= (st_q[1] == IS_RESET);
         adc_busy_q   <= (st_q[0] == IS_CONVERT_STROBE) | (st_q[1] == IS_CONVERT_STROBE);
         adc_side_b_q <= (st_q[1] == IS_CONVERT_STROBE);
         adc_mux_hi_q <= (st_q[0] == IS_CONVERT_STROBE && tick_q[0] >= TCK_W'(T_CONVERT_STROBE / 2))
                       | (st_q[1] == IS_CONVERT_STROBE && tick_q[1] >= TCK_W'(T_CONVERT_STROBE / 2));
      end
   end

endmodule
`default_nettype wire

// file: hw/isc_host.sv
`timescale 1ns/100ps
`default_nettype none
module isc_host
   import isc_pkg::*;
#(
   parameter int RD_BITS  = RB_TOTAL_SHORT,
   parameter int DAT_BITS = 2 * NUM_IN * RES_W
) (
   // clock, reset, enable
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // link to the device
   isc_link_if.host               lnk,
   // user commands
   input  wire logic              cfg_start,
   input  wire logic [CFG_W-1:0]  cfg_word,
   input  wire logic              rb_en,
   input  wire logic              convert_strobe_req,
   // user results
   output logic                   busy_q,
   output logic                   rx_bit_q,
   output logic                   rx_valid_q,
   output logic                   rx_data_q
);

   localparam int CW = 16;

   isc_host_t        st_q;
   logic [CW-1:0]    cnt_q, bit_q, sys_cnt_q;
   logic [CFG_W-1:0] sh_q;
   logic             phase_q;
   logic             sys_q, convert_strobe_q, rstn_q, sck_q, din_q, data_shift_clock_q;
   logic [1:0]       dout_s_q, rdy_s_q;

   // system clock from a divider; the strobe changes only at its rising edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sys_cnt_q <= '0;
         sys_q     <= 1'b0;
         convert_strobe_q    <= 1'b0;
      end else if (clk_en) begin
         if (sys_cnt_q == CW'(SYS_HALF - 1)) begin
            sys_cnt_q <= '0;
            sys_q     <= ~sys_q;
            if (!sys_q) convert_strobe_q <= convert_strobe_req & (st_q == H_IDLE);
         end else begin
            sys_cnt_q <= sys_cnt_q + 1'b1;
         end
      end
   end

   // device outputs cross into this clock through two flops
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dout_s_q <= '0;
         rdy_s_q  <= 2'h3;
      end else if (clk_en) begin
         dout_s_q <= {dout_s_q[0], lnk.serial_data_out};
         rdy_s_q  <= {rdy_s_q[0], lnk.output_ready_n};
      end
   end

   // sequencer: reset pulse, waits, write, optional readback, result reads
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q       <= H_IDLE;
         cnt_q      <= '0;
         bit_q      <= '0;
         sh_q       <= '0;
         phase_q    <= 1'b0;
         rstn_q     <= 1'b1;
         sck_q      <= 1'b0;
         din_q      <= 1'b0;
         data_shift_clock_q     <= 1'b0;
         rx_bit_q   <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_data_q  <= 1'b0;
      end else if (clk_en) begin
         rx_valid_q <= 1'b0;
         case (st_q)
            H_IDLE: begin
               cnt_q   <= '0;
               bit_q   <= '0;
               phase_q <= 1'b0;
               if (cfg_start) begin
                  st_q   <= H_RST;
                  rstn_q <= 1'b0;
                  sh_q   <= cfg_word;
               end else if (!rdy_s_q[1] && !convert_strobe_q) begin
                  st_q      <= H_DATA;
                  rx_data_q <= 1'b1;
               end
            end
            H_RST: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CW'(RST_CYC - 1)) begin
                  rstn_q <= 1'b1;
                  cnt_q  <= '0;
                  st_q   <= H_WRST;
               end
            end
            H_WRST: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CW'(WTRST_CYC - 1)) begin
                  cnt_q <= '0;
                  din_q <= sh_q[CFG_W-1];
                  st_q  <= H_WR;
               end
            end
            H_WR: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CW'(SCK_HALF - 1)) begin
                  cnt_q   <= '0;
                  phase_q <= ~phase_q;
                  sck_q   <= ~phase_q;
                  if (phase_q) begin
                     // data stays put at the fall, so the device captures a held bit
                     sh_q  <= {sh_q[CFG_W-2:0], 1'b0};
                     bit_q <= bit_q + 1'b1;
                     if (bit_q == CW'(CFG_W - 1)) st_q <= H_WWR;
                  end else begin
                     din_q <= sh_q[CFG_W-1];
                  end
               end
            end
            H_WWR: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CW'(WTWR_CYC - 1)) begin
                  din_q     <= 1'b0;
                  cnt_q     <= '0;
                  bit_q     <= '0;
                  rx_data_q <= 1'b0;
                  st_q      <= rb_en ? H_RD : H_IDLE;
               end
            end
            H_RD, H_DATA: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CW'(SCK_HALF - 1)) begin
                  cnt_q   <= '0;
                  phase_q <= ~phase_q;
                  data_shift_clock_q  <= ~phase_q;
                  if (!phase_q) begin
                     rx_bit_q   <= dout_s_q[1];
                     rx_valid_q <= 1'b1;
                  end else begin
                     bit_q <= bit_q + 1'b1;
                     if (bit_q == CW'((st_q == H_RD ? RD_BITS : DAT_BITS) - 1)) st_q <= H_IDLE;
                  end
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // busy whenever the sequencer is away from idle
   always_ff @(posedge core_clk) begin
      if (sys_rst) busy_q <= 1'b0;
      else if (clk_en) busy_q <= (st_q != H_IDLE) | cfg_start;
   end

   assign lnk.system_clock       = sys_q;
   assign lnk.convert_strobe     = convert_strobe_q;
   assign lnk.cfg_reset_n        = rstn_q;
   assign lnk.config_shift_clock = sck_q;
   assign lnk.config_serial_in   = din_q;
   assign lnk.data_shift_clock   = data_shift_clock_q;

endmodule
`default_nettype wire

// file: tb/isc_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
module isc_link_checker
   import isc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // link signals
   input wire logic system_clock,
   input wire logic convert_strobe,
   input wire logic cfg_reset_n,
   input wire logic config_shift_clock,
   input wire logic data_shift_clock,
   input wire logic output_ready_n
);
   logic [15:0] low_q;
   logic [15:0] high_q;
   logic [15:0] gap_q;
   logic [3:0]  nfall_q;
   logic [3:0]  flat_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // low_q, high_q and gap_q saturate, so long idle stretches never wrap into false passes
   always_ff @(posedge core_clk) begin
      low_q  <= (sys_rst || cfg_reset_n) ? 16'h0000 : low_q + {15'h0000, ~&low_q};
      high_q <= (sys_rst || !cfg_reset_n) ? 16'h0000 : high_q + {15'h0000, ~&high_q};
      gap_q  <= sys_rst ? 16'hFFFF : $fell(config_shift_clock) ? 16'h0000
                : gap_q + {15'h0000, ~&gap_q};
      nfall_q <= (sys_rst || !cfg_reset_n) ? 4'h0
                 : nfall_q + {3'h0, $fell(config_shift_clock)};
      flat_q <= (sys_rst || $changed(system_clock)) ? 4'h0 : flat_q + 4'h1;
   end

   // data clock parked low long enough that no rise is still in the synchroniser
   sequence data_shift_clock_idle;
      !data_shift_clock[*5];
   endsequence

   strobe_low_cfg_a: assert property (!cfg_reset_n |-> !convert_strobe)
      else $error("convert strobe high during config reset");
   reset_width_a: assert property ($rose(cfg_reset_n) |-> low_q >= 16'(RST_CYC))
      else $error("config reset pulse too short");
   settle_wait_a: assert property ($rose(config_shift_clock) |-> high_q >= 16'(WTRST_CYC))
      else $error("shift clock too soon after config reset");
   write_gap_a: assert property ($rose(data_shift_clock) |-> gap_q >= 16'(WTWR_CYC))
      else $error("readback too soon after write");
   whole_word_a: assert property ($fell(cfg_reset_n) |-> nfall_q == 4'h0 || nfall_q == 4'hC)
      else $error("partial config word sent");
   no_extra_a: assert property ($fell(config_shift_clock) |-> nfall_q < 4'hC)
      else $error("more than twelve config bits");
   strobe_sync_a: assert property ($changed(convert_strobe) |->
      system_clock && !$past(system_clock, 2))
      else $error("convert strobe moved away from clock rise");
   clock_runs_a: assert property (flat_q < 4'hC)
      else $error("system clock stopped");
   ready_hold_a: assert property (data_shift_clock_idle ##0 !output_ready_n |=> !output_ready_n)
      else $error("ready released without data clock");
endmodule
`default_nettype wire

// file: tb/integrator_sequencer_config_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module integrator_sequencer_config_port_bench;
   import isc_pkg::*;
   logic         core_clk, sys_rst, cfg_start, rb_en, convert_strobe_req;
   logic         busy_q, rx_bit_q, rx_valid_q, rx_data_q;
   logic         integ_a_q, integ_b_q, adc_busy_q, adc_side_b_q;
   logic         clk_en, ref_conn_a_q, adc_mux_hi_q;
   logic [4:0]   res_idx;
   logic [11:0]  cfg_word, cfg_word_q, fs_charge_q;
   logic [2:0]   full_scale_q, last_rng;
   logic [9:0]   fb_cap_q;
   logic [639:0] rx_v;
   int           bad_count, checks, cyc, n;

   isc_link_if lnk ();
   // daisy input held high so chained bits are told apart from the zero pattern
   assign lnk.chain_in = 1'b1;

   isc_dev #(.T_CONVERT_STROBE(4), .T_RESET(2)) i_isc_dev (.core_clk, .sys_rst, .clk_en,
      .lnk(lnk.dev), .res_we(adc_busy_q), .res_idx,
      .res_data(adc_side_b_q ? 20'hBBBBB : 20'hAAAAA), .cfg_word_q, .full_scale_q,
      .fb_cap_q, .fs_charge_q, .integ_a_q, .integ_b_q, .ref_conn_a_q, .ref_conn_b_q(),
      .adc_busy_q, .adc_side_b_q, .adc_mux_hi_q, .convert_strobe_done_q());
   isc_host #(.RD_BITS(640), .DAT_BITS(40)) i_isc_host (.core_clk, .sys_rst,
      .clk_en, .lnk(lnk.host), .cfg_start, .cfg_word, .rb_en, .convert_strobe_req, .busy_q,
      .rx_bit_q, .rx_valid_q, .rx_data_q);
   isc_link_checker i_isc_link_checker (.core_clk, .sys_rst,
      .system_clock(lnk.system_clock), .convert_strobe(lnk.convert_strobe),
      .cfg_reset_n(lnk.cfg_reset_n), .config_shift_clock(lnk.config_shift_clock),
      .data_shift_clock(lnk.data_shift_clock), .output_ready_n(lnk.output_ready_n));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // every received bit, readback and results alike, lands here msb first
   always @(posedge core_clk) begin
      if (rx_valid_q === 1'b1) rx_v <= {rx_v[638:0], rx_bit_q};
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [639:0] got, input logic [639:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_idle();
      n = 0;
      while (busy_q !== 1'b0 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // mid-write the old range must still be in force
   task automatic cfg_write(input logic [11:0] w, input logic rb);
      @(negedge core_clk);
      cfg_word = w;
      rb_en = rb;
      cfg_start = 1'b1;
      @(negedge core_clk);
      cfg_start = 1'b0;
      // by now eight bits are in, the commit is still some cycles away
      repeat (400) @(negedge core_clk);
      chk(full_scale_q, last_rng);
      wait_idle();
      last_rng = w[11:9];
      chk(cfg_word_q, w);
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      {sys_rst, cfg_start, rb_en, convert_strobe_req, cfg_word, last_rng} = {4'h8, 12'h000, 3'h7};
      {bad_count, checks, cyc, rx_v} = '0;
      {clk_en, res_idx} = {1'b1, 5'h00};
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      // enable low: a start pulse is ignored and the divider stands still
      clk_en = 1'b0;
      cfg_start = 1'b1;
      @(negedge core_clk);
      cfg_start = 1'b0;
      repeat (3) @(negedge core_clk);
      chk({busy_q, lnk.system_clock, lnk.cfg_reset_n}, 3'h1);
      clk_en = 1'b1;
      $display("test freeze done");
      // every range code, one write each, capacitor and charge ascending
      for (int c = 0; c < 8; c++) begin
         cfg_write({c[2:0], 9'h000}, 1'b0);
         chk(full_scale_q, c[2:0]);
         chk(fb_cap_q, (c == 0) ? 30 : 125 * c);
         chk(fs_charge_q, (c == 0) ? 125 : 500 * c);
      end
      $display("test ranges done");
      cfg_write(12'h600, 1'b1);
      chk(rx_v, {{2{12'h600, REV_ID, 184'h0, 56'h30F066012480F6}}, {128{1'b1}}});
      chk(rx_data_q, 1'b0);
      cfg_write(12'hF00, 1'b1);
      chk(rx_v, {2{12'hF00, REV_ID, 232'h0, 72'h30F066012480F69055}});
      $display("test readback done");
      @(negedge core_clk);
      convert_strobe_req = 1'b1;
      wait (lnk.convert_strobe === 1'b1);
      repeat (8) @(negedge core_clk);
      chk(integ_a_q, 1'b1);
      repeat (100) @(negedge core_clk);
      convert_strobe_req = 1'b0;
      wait (lnk.convert_strobe === 1'b0);
      repeat (8) @(negedge core_clk);
      chk({integ_a_q, integ_b_q, adc_busy_q, adc_side_b_q, adc_mux_hi_q}, 5'h0C);
      // second half of the conversion time switches the converters to the upper inputs
      repeat (32) @(negedge core_clk);
      chk(adc_mux_hi_q, 1'b1);
      wait (lnk.output_ready_n === 1'b0);
      repeat (8) @(negedge core_clk);
      chk({ref_conn_a_q, adc_busy_q}, 2'h2);
      wait_idle();
      chk({rx_data_q, rx_v[39:20]}, 21'h1AAAAA);
      convert_strobe_req = 1'b1;
      wait (lnk.convert_strobe === 1'b1);
      repeat (8) @(negedge core_clk);
      chk({integ_a_q, adc_busy_q, adc_side_b_q}, 3'h7);
      $display("test conversion done");
      wrap_up();
   end
endmodule
`default_nettype wire
